// ---- src/rsc_status_ctl.sv ----
`timescale 1ns/100ps
`include "rsc_defs.svh"
// Summary of operation
// R1: Oscillator failure detection sets the oscillator fail flag.
// R2: Forward daylight adjustment sets the applied flag; reverse adjustment clears it.
// R3: Daylight applied flag is read-only; loading a time never sets it.
// R4: Host enables daylight saving over an hour before the programmed event.
// R5: Applied flag clears at power-up and whenever daylight saving is disabled.
// R6: Alarm match sets the alarm flag; host writes can only clear it.
// R7: Alarm set during a status read survives that read's automatic clear.
// R8: On mains, low-supply flag follows the brownout comparator in real time.
// R9: On mains, battery flags sample both comparators when seconds reach 59.
// R10: Setting the temperature sense bit also triggers a battery sampling cycle.
// R11: On battery, sample at minutes x9 or x0; present result on return.
// R12: Total power loss flag set at power-up after both supplies were lost.
// R13: First valid timekeeping write clears the total power loss flag.
// R14: With auto clear, status read ending in stop clears four flags.
// R15: Write enable defaults off, gates time writes; stop aligns the second tick.
// R16: Pulse mode drives a 250 ms low pulse on every alarm match.
// R17: Level mode holds the pin low until the alarm flag is cleared.
// R18: Backup pin disable turns the pin off while running from battery.
// R19: Frequency code maps off, 32768 Hz down to 1/32 Hz; default code 1.
// R20: A nonzero frequency code overrides alarm signalling on the pin.
// R21: Writing the stamp clear bit clears both time stamp register sets.
// R22: Three-bit trip selector picks one of six brownout thresholds.
// R23: Trip codes 110 and 111 are stored but their effect is unspecified.
module rsc_status_ctl #(
  parameter int PULSE_CYCLES = `RSC_PULSE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire rsc_pkg::rsc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire rsc_pkg::rsc_analog_t analog_raw,
  input wire logic osc_clk_raw,
  input wire rsc_pkg::rsc_time_evt_t time_evt,
  input wire logic total_loss_strap,
  input wire logic dst_enable_bit,
  output logic [2:0] supply_trip_select,
  output logic timekeeping_write_enable,
  output logic rtc_wr_grant,
  output logic tick_align,
  output logic stamp_clear,
  output logic irq_fout_o,
  output logic irq_fout_oe
);
  import rsc_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync_q;
  rsc_analog_t ana;
  logic osc_level;

  rsc_sync2 #(.W(6)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .d({osc_clk_raw, analog_raw}),
    .q(sync_q)
  );

  assign ana = rsc_analog_t'(sync_q[4:0]);
  assign osc_level = sync_q[5];

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [7:0] interrupt_control;
  logic [7:0] supply_control;
  logic osc_fail_flag;
  logic dst_applied_flag;
  logic alarm_match_flag;
  logic low_main_supply_flag;
  logic battery_low_first_flag;
  logic battery_low_second_flag;
  logic total_power_loss_flag;
  logic [7:0] status_flags;

  wire sel_status = reg_req.addr == `RSC_ADDR_STATUS;
  wire sel_intctl = reg_req.addr == `RSC_ADDR_INTCTL;
  wire sel_supctl = reg_req.addr == `RSC_ADDR_SUPCTL;
  wire wr_status = reg_req.wr & sel_status;
  wire wr_intctl = reg_req.wr & sel_intctl;
  wire wr_supctl = reg_req.wr & sel_supctl;
  wire rd_status = reg_req.rd & sel_status;

  wire auto_clear_enable = interrupt_control[`RSC_IC_AUTOCLR];
  wire alarm_pulse_select = interrupt_control[`RSC_IC_PULSE];
  wire backup_pin_disable = interrupt_control[`RSC_IC_BKDIS];
  wire [3:0] freq_out_select = interrupt_control[`RSC_IC_FREQ_LSB +: 4];

  assign timekeeping_write_enable = interrupt_control[`RSC_IC_WEN];
  assign supply_trip_select = supply_control[`RSC_SC_TRIP_LSB +: 3]; // R22 R23
  assign rtc_wr_grant = time_evt.rtc_wr_req & timekeeping_write_enable; // R15

  assign status_flags = {1'b0, osc_fail_flag, dst_applied_flag, alarm_match_flag,
                         low_main_supply_flag, battery_low_first_flag,
                         battery_low_second_flag, total_power_loss_flag};

  wire [7:0] rd_mux = sel_status ? status_flags :
                      sel_intctl ? interrupt_control :
                      sel_supctl ? supply_control : 8'h00;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_control <= `RSC_INTCTL_RST;
      supply_control <= `RSC_SUPCTL_RST;
      reg_rdata <= 8'h00;
      stamp_clear <= 1'b0;
    end else if (ce) begin
      if (wr_intctl) interrupt_control <= reg_req.wdata;
      if (wr_supctl) supply_control <= reg_req.wdata;
      if (reg_req.rd) reg_rdata <= rd_mux;
      stamp_clear <= wr_supctl & reg_req.wdata[`RSC_SC_STAMP]; // R21
    end
  end

  // ----------------------------------------------------------------
  // Status read window and automatic clearing
  // ----------------------------------------------------------------
  // An alarm that lands inside the read window must not be wiped by
  // the clear that the same read earns at its stop.
  logic rd_window;
  logic alm_in_read;
  wire hit = time_evt.alarm_hit;
  wire autoclr_go = reg_req.stop & rd_window & auto_clear_enable; // R14
  wire clr_alm = (autoclr_go & ~alm_in_read) | (wr_status & ~reg_req.wdata[`RSC_ST_ALM]);
  wire clr_low = autoclr_go | (wr_status & ~reg_req.wdata[`RSC_ST_LOW]);
  wire clr_bat1 = autoclr_go | (wr_status & ~reg_req.wdata[`RSC_ST_BAT1]);
  wire clr_bat2 = autoclr_go | (wr_status & ~reg_req.wdata[`RSC_ST_BAT2]);
  wire clr_osc = wr_status & ~reg_req.wdata[`RSC_ST_OSC];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_window <= 1'b0;
      alm_in_read <= 1'b0;
    end else if (ce) begin
      rd_window <= ~reg_req.stop & (rd_window | rd_status);
      alm_in_read <= ~reg_req.stop & (alm_in_read | (hit & (rd_window | rd_status))); // R7
    end
  end

  // ----------------------------------------------------------------
  // Oscillator, daylight saving and alarm flags
  // ----------------------------------------------------------------
  wire dst_set = time_evt.dst_fwd & dst_enable_bit;
  wire dst_clr = time_evt.dst_rev | ~dst_enable_bit;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_fail_flag <= 1'b0;
      dst_applied_flag <= 1'b0; // R5
      alarm_match_flag <= 1'b0;
    end else if (ce) begin
      osc_fail_flag <= ana.osc_bad | (osc_fail_flag & ~clr_osc); // R1
      // Only the forward event sets this; writes and time loads never do.
      dst_applied_flag <= dst_set | (dst_applied_flag & ~dst_clr); // R2 R3 R5
      alarm_match_flag <= hit | (alarm_match_flag & ~clr_alm); // R6 R14
    end
  end

  // ----------------------------------------------------------------
  // Supply and battery monitors
  // ----------------------------------------------------------------
  logic was_batt;
  logic pend_valid;
  logic pend_first;
  logic pend_second;
  wire on_batt = ana.on_battery;
  wire min_hit = (time_evt.min_ones == `RSC_MIN_X9) | (time_evt.min_ones == `RSC_MIN_X0);
  wire samp_mains = ~on_batt & (time_evt.sec59 | time_evt.tse_set); // R9 R10
  wire samp_batt = on_batt & time_evt.min_tick & min_hit; // R11
  wire resume = ~on_batt & was_batt & pend_valid;
  wire bat_apply = samp_mains | resume;
  wire val_first = samp_mains ? ana.batt_below_first : pend_first;
  wire val_second = samp_mains ? ana.batt_below_second : pend_second;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      was_batt <= 1'b0;
      pend_valid <= 1'b0;
      pend_first <= 1'b0;
      pend_second <= 1'b0;
    end else if (ce) begin
      was_batt <= on_batt;
      if (samp_batt) begin
        pend_valid <= 1'b1;
        pend_first <= ana.batt_below_first;
        pend_second <= ana.batt_below_second;
      end else if (resume) begin
        pend_valid <= 1'b0;
      end
    end
  end

  // The brownout comparator is meaningless on battery, so the flag holds there until a status write or auto clear clears it.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_main_supply_flag <= 1'b0;
      battery_low_first_flag <= 1'b0;
      battery_low_second_flag <= 1'b0;
    end else if (ce) begin
      low_main_supply_flag <= on_batt ? (low_main_supply_flag & ~clr_low) :
                              ana.vdd_below; // R8
      battery_low_first_flag <= bat_apply ? val_first :
                                (battery_low_first_flag & ~clr_bat1); // R9 R11
      battery_low_second_flag <= bat_apply ? val_second :
                                 (battery_low_second_flag & ~clr_bat2); // R9 R11
    end
  end

  // ----------------------------------------------------------------
  // Total power loss flag and write alignment
  // ----------------------------------------------------------------
  // The strap is caught on the first enabled edge after reset release.
  logic strap_done;
  logic align_pend;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_done <= 1'b0;
      total_power_loss_flag <= 1'b0;
      align_pend <= 1'b0;
      tick_align <= 1'b0;
    end else if (ce) begin
      strap_done <= 1'b1;
      if (!strap_done) total_power_loss_flag <= total_loss_strap; // R12
      else if (rtc_wr_grant) total_power_loss_flag <= 1'b0; // R13
      align_pend <= ~reg_req.stop & (align_pend | rtc_wr_grant);
      tick_align <= reg_req.stop & (align_pend | rtc_wr_grant); // R15
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and frequency pin
  // ----------------------------------------------------------------
  logic wave;
  logic pulse_active;
  rsc_pin_mode_t pin_mode;

  rsc_fout_gen #(.PULSE_CYCLES(PULSE_CYCLES)) u_fout (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .osc_level(osc_level),
    .freq_sel(freq_out_select),
    .alarm_hit(hit),
    .pulse_mode(alarm_pulse_select),
    .wave(wave),
    .pulse_active(pulse_active)
  );

  assign pin_mode = (on_batt & backup_pin_disable) ? RSC_PIN_OFF : // R18
                    (freq_out_select != `RSC_FREQ_OFF) ? RSC_PIN_FREQ : // R20
                    alarm_pulse_select ? RSC_PIN_PULSE : RSC_PIN_LEVEL;
  // The pin is open drain: it only ever pulls low.
  assign irq_fout_o = 1'b0;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_fout_oe <= 1'b0;
    end else if (ce) begin
      case (pin_mode)
        RSC_PIN_OFF: irq_fout_oe <= 1'b0; // R18
        RSC_PIN_FREQ: irq_fout_oe <= ~wave; // R20
        RSC_PIN_PULSE: irq_fout_oe <= pulse_active; // R16
        default: irq_fout_oe <= alarm_match_flag; // R17
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_hit_in_read;
    ce && rd_window && hit;
  endsequence
  sequence s_stop_now;
    ce && reg_req.stop;
  endsequence

  AST_OSC_SET: assert property (ce && ana.osc_bad |=> osc_fail_flag) // R1
    else $error("oscillator fail not flagged");
  AST_DST_FWD: assert property (ce && dst_set |=> dst_applied_flag) // R2
    else $error("forward adjustment not flagged");
  AST_DST_RO: assert property (ce && wr_status && !dst_set && !dst_clr |=> // R3
    dst_applied_flag == $past(dst_applied_flag))
    else $error("daylight flag changed by a write");
  AST_DST_OFF: assert property (ce && !dst_enable_bit |=> !dst_applied_flag) // R5
    else $error("daylight flag kept while disabled");
  AST_ALM_SET: assert property (ce && hit |=> alarm_match_flag) // R6
    else $error("alarm match not flagged");
  AST_ALM_READ: assert property (s_hit_in_read ##1 s_stop_now |=> alarm_match_flag) // R7
    else $error("alarm lost by read clear");
  AST_LOW: assert property (ce && !on_batt |=> low_main_supply_flag == $past(ana.vdd_below)) // R8
    else $error("low supply flag not tracking comparator");
  AST_BAT: assert property (ce && samp_mains |=> // R9 R10
    battery_low_second_flag == $past(ana.batt_below_second))
    else $error("battery sample not applied");
  AST_AUTOCLR: assert property (ce && autoclr_go && !samp_mains && !resume |=> // R14
    !battery_low_first_flag)
    else $error("auto clear missed");
  AST_TPL_CLR: assert property (ce && strap_done && rtc_wr_grant |=> !total_power_loss_flag) // R13
    else $error("power loss flag not cleared");
  AST_TICK_ALIGN: assert property (ce && align_pend && reg_req.stop |=> tick_align) // R15
    else $error("stop after a time write did not align the tick");
  AST_PIN_OFF: assert property (ce && on_batt && backup_pin_disable |=> !irq_fout_oe) // R18
    else $error("pin driven in backup while disabled");
  AST_LEVEL: assert property (ce && pin_mode == RSC_PIN_LEVEL |=> // R17
    irq_fout_oe == $past(alarm_match_flag))
    else $error("level mode pin does not follow flag");
endmodule : rsc_status_ctl

// ---- shared/rsc_defs.svh ----
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RSC_ADDR_STATUS 8'h07
`define RSC_ADDR_INTCTL 8'h08
`define RSC_ADDR_SUPCTL 8'h09

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define RSC_ST_OSC 6
`define RSC_ST_DST 5
`define RSC_ST_ALM 4
`define RSC_ST_LOW 3
`define RSC_ST_BAT1 2
`define RSC_ST_BAT2 1
`define RSC_ST_TPL 0

// ----------------------------------------------------------------
// Interrupt control and supply control fields
// ----------------------------------------------------------------
`define RSC_IC_AUTOCLR 7
`define RSC_IC_WEN 6
`define RSC_IC_PULSE 5
`define RSC_IC_BKDIS 4
`define RSC_IC_FREQ_LSB 0
`define RSC_SC_STAMP 7
`define RSC_SC_TRIP_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RSC_INTCTL_RST 8'h01
`define RSC_SUPCTL_RST 8'h00

// ----------------------------------------------------------------
// Timing and codes
// ----------------------------------------------------------------
`define RSC_CLK_KHZ 10000
`define RSC_PULSE_MS 250
`define RSC_PULSE_CYCLES (`RSC_PULSE_MS * `RSC_CLK_KHZ)
`define RSC_MIN_X9 4'h9
`define RSC_MIN_X0 4'h0
`define RSC_FREQ_OFF 4'h0
`define RSC_FREQ_XTAL 4'h1

`endif

// ---- shared/rsc_pkg.sv ----
package rsc_pkg;

  // ----------------------------------------------------------------
  // Register access from the serial interface logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic stop;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsc_reg_req_t;

  // ----------------------------------------------------------------
  // Analog comparator and supply-switch levels, not on core_clk
  // ----------------------------------------------------------------
  typedef struct packed {
    logic osc_bad;
    logic on_battery;
    logic vdd_below;
    logic batt_below_first;
    logic batt_below_second;
  } rsc_analog_t;

  // ----------------------------------------------------------------
  // Events from the timekeeping logic, on core_clk
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sec59;
    logic min_tick;
    logic [3:0] min_ones;
    logic tse_set;
    logic dst_fwd;
    logic dst_rev;
    logic alarm_hit;
    logic rtc_wr_req;
  } rsc_time_evt_t;

  typedef enum logic [1:0] {
    RSC_PIN_OFF,
    RSC_PIN_FREQ,
    RSC_PIN_PULSE,
    RSC_PIN_LEVEL
  } rsc_pin_mode_t;

endpackage : rsc_pkg

// ---- src/rsc_sync2.sv ----
`timescale 1ns/100ps
module rsc_sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : rsc_sync2

// ---- src/rsc_fout_gen.sv ----
`timescale 1ns/100ps
`include "rsc_defs.svh"
module rsc_fout_gen #(
  parameter int PULSE_CYCLES = `RSC_PULSE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic osc_level,
  input wire logic [3:0] freq_sel,
  input wire logic alarm_hit,
  input wire logic pulse_mode,
  output logic wave,
  output logic pulse_active
);
  import rsc_pkg::*;

  logic osc_prev;
  logic [19:0] div;
  logic [21:0] pulse_cnt;
  logic [15:0] taps;
  wire osc_rise = osc_level & ~osc_prev;
  wire pulse_load = alarm_hit & pulse_mode;

  // Each divider bit halves the crystal rate; code 1 passes the crystal itself.
  assign taps = {div[19:8], div[4], div[2], osc_level, 1'b1};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_prev <= 1'b0;
      div <= 20'h0;
      wave <= 1'b1;
    end else if (ce) begin
      osc_prev <= osc_level;
      div <= osc_rise ? div + 20'h1 : div;
      wave <= taps[freq_sel]; // R19
    end
  end

  // A new match restarts the pulse, so matches close together merge.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_cnt <= 22'h0;
      pulse_active <= 1'b0;
    end else if (ce) begin
      if (pulse_load) begin // R16
        pulse_cnt <= 22'(PULSE_CYCLES - 1);
        pulse_active <= 1'b1;
      end else if (pulse_cnt != 22'h0) begin
        pulse_cnt <= pulse_cnt - 22'h1;
      end else begin
        pulse_active <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_pulse_start;
    ce && alarm_hit && pulse_mode;
  endsequence

  AST_PULSE_LOAD: assert property (s_pulse_start |=> // R16
    pulse_active && pulse_cnt == 22'(PULSE_CYCLES - 1))
    else $error("pulse did not start with full length");
  AST_XTAL_PASS: assert property (ce && freq_sel == `RSC_FREQ_XTAL |=> // R19
    wave == $past(osc_level))
    else $error("crystal rate not passed to the pin");
  AST_FREQ_OFF: assert property (ce && freq_sel == `RSC_FREQ_OFF |=> wave) // R19
    else $error("off code still toggles the wave");
endmodule : rsc_fout_gen

// ---- verification/rsc_pin_model.sv ----
`timescale 1ns/100ps
module rsc_pin_model (
  input wire logic core_clk,
  input wire logic irq_fout_o,
  input wire logic irq_fout_oe,
  output logic pin_level,
  output int falls
);
  logic last = 1'b1;

  // ----------------------------------------------------------------
  // Open-drain line and interrupt consumer
  // ----------------------------------------------------------------
  // The pull-up returns the line high as soon as the device lets go.
  assign pin_level = irq_fout_oe ? irq_fout_o : 1'b1;

  // The consumer sees only sampled edges, so glitches shorter than a cycle are not counted.
  always @(posedge core_clk) begin
    if (last === 1'b1 && pin_level === 1'b0) falls <= falls + 1;
    last <= pin_level;
  end
endmodule : rsc_pin_model

// ---- verification/test_rtc_status_interrupt_control.sv ----
`timescale 1ns/100ps
`include "rsc_defs.svh"
module test_rtc_status_interrupt_control;
  import rsc_pkg::*;
  logic core_clk = 0, rst_b = 0, ce = 1, osc = 0, strap = 1, dst_en = 0;
  rsc_reg_req_t req = '0;
  rsc_analog_t ana = '0;
  rsc_time_evt_t tev = '0;
  logic [7:0] rdata, v;
  logic [2:0] trip, code;
  logic wen, grant, talign, sclr, pin_o, pin_oe, pin, b1, b2, seen;
  int n_mismatch = 0, compares = 0, falls, f0, lows, i;

  rsc_status_ctl #(.PULSE_CYCLES(20)) u_dut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
    .reg_req(req), .reg_rdata(rdata), .analog_raw(ana), .osc_clk_raw(osc), .time_evt(tev),
    .total_loss_strap(strap), .dst_enable_bit(dst_en), .supply_trip_select(trip),
    .timekeeping_write_enable(wen), .rtc_wr_grant(grant), .tick_align(talign),
    .stamp_clear(sclr), .irq_fout_o(pin_o), .irq_fout_oe(pin_oe));
  rsc_pin_model u_pin (.core_clk(core_clk), .irq_fout_o(pin_o), .irq_fout_oe(pin_oe),
    .pin_level(pin), .falls(falls));

  initial forever #50 core_clk = ~core_clk;
  // Crystal at 32.768 kHz, free-running and unrelated to the core clock.
  initial forever #15259 osc = ~osc;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] fld(input int b, input logic x);
    fld = {7'h00, x} << b;
  endfunction : fld

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    req.wr = 1;
    req.addr = a;
    req.wdata = d;
    tick(1);
    req.wr = 0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    tick(1);
    req.rd = 1;
    req.addr = a;
    tick(1);
    v = rdata;
    req.rd = 0;
  endtask : rd

  task automatic stop();
    tick(1);
    req.stop = 1;
    tick(1);
    req.stop = 0;
  endtask : stop

  // Bit order: sec59, min_tick, min_ones[3:0], tse, fwd, rev, alarm, wr_req.
  task automatic evt(input rsc_time_evt_t e);
    tick(1);
    tev = e;
    tick(1);
    tev = '0;
  endtask : evt

  task automatic cst(input int b, input logic x);
    rd(`RSC_ADDR_STATUS);
    chk(v & fld(b, 1'b1), fld(b, x));
  endtask : cst

  task automatic count_low(input int n);
    lows = 0;
    repeat (n) begin
      tick(1);
      if (pin === 1'b0) lows++;
    end
  endtask : count_low

  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  initial begin
    #4000000;
    n_mismatch++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    i = $urandom(32'h7dc00791);
    tick(12);
    rst_b = 1;
    rd(`RSC_ADDR_INTCTL); chk(v, `RSC_INTCTL_RST);
    rd(`RSC_ADDR_SUPCTL); chk(v, `RSC_SUPCTL_RST);
    rd(8'h0a); chk(v, 8'h00);
    cst(`RSC_ST_TPL, 1);
    tev.rtc_wr_req = 1;
    #1 chk({7'h0, grant}, 8'h00);
    tick(1);
    tev.rtc_wr_req = 0;
    cst(`RSC_ST_TPL, 1);
    wr(`RSC_ADDR_INTCTL, 8'h40);
    chk({7'h0, wen}, 8'h01);
    tev.rtc_wr_req = 1;
    #1 chk({7'h0, grant}, 8'h01);
    tick(1);
    tev.rtc_wr_req = 0;
    req.stop = 1;
    tick(1);
    req.stop = 0;
    chk({7'h0, talign}, 8'h01);
    cst(`RSC_ST_TPL, 0);
    $display("test reset and time write done");
    evt(11'h002); cst(`RSC_ST_ALM, 1);
    wr(`RSC_ADDR_STATUS, 8'hff); cst(`RSC_ST_ALM, 1);
    cst(`RSC_ST_DST, 0);
    wr(`RSC_ADDR_STATUS, 8'h00); cst(`RSC_ST_ALM, 0);
    wr(`RSC_ADDR_INTCTL, 8'hc0);
    // Close the status-read window that the reads above left open.
    stop();
    evt(11'h002); cst(`RSC_ST_ALM, 1);
    stop(); cst(`RSC_ST_ALM, 0);
    rd(`RSC_ADDR_STATUS);
    tick(1);
    tev.alarm_hit = 1;
    tick(1);
    tev = '0;
    req.stop = 1;
    tick(1);
    req.stop = 0;
    cst(`RSC_ST_ALM, 1);
    $display("test alarm flag done");
    wr(`RSC_ADDR_INTCTL, 8'h20);
    for (i = 0; i < 2; i++) begin
      evt(11'h002); count_low(40); chk(8'(lows), 8'd20);
    end
    wr(`RSC_ADDR_INTCTL, 8'h00);
    wr(`RSC_ADDR_STATUS, 8'h00);
    evt(11'h002); tick(3); count_low(20); chk(8'(lows), 8'd20);
    wr(`RSC_ADDR_STATUS, 8'h00); tick(3); count_low(10); chk(8'(lows), 8'd0);
    for (i = 0; i < 2; i++) begin
      wr(`RSC_ADDR_INTCTL, i[0] ? 8'h30 : 8'h20);
      ana.on_battery = 1;
      tick(4);
      evt(11'h002); count_low(40); chk(8'(lows), i[0] ? 8'd0 : 8'd20);
      ana.on_battery = 0;
      tick(4);
    end
    $display("test pin modes done");
    ana.vdd_below = 1; tick(5); cst(`RSC_ST_LOW, 1);
    ana.vdd_below = 0; tick(5); cst(`RSC_ST_LOW, 0);
    ana.osc_bad = 1; tick(5); cst(`RSC_ST_OSC, 1);
    ana.osc_bad = 0;
    for (i = 0; i < 6; i++) begin
      {b1, b2} = 2'($urandom);
      ana.batt_below_first = b1;
      ana.batt_below_second = b2;
      tick(4);
      evt(i[0] ? 11'h010 : 11'h400);
      rd(`RSC_ADDR_STATUS); chk(v & 8'h06, fld(`RSC_ST_BAT1, b1) | fld(`RSC_ST_BAT2, b2));
    end
    ana.batt_below_second = 0; tick(4); evt(11'h400);
    ana.on_battery = 1; ana.batt_below_second = 1; tick(4);
    evt(11'h2a0); ana.on_battery = 0; tick(5); cst(`RSC_ST_BAT2, 0);
    ana.on_battery = 1; tick(4);
    evt(11'h320); cst(`RSC_ST_BAT2, 0);
    ana.on_battery = 0; tick(5); cst(`RSC_ST_BAT2, 1);
    dst_en = 1;
    evt(11'h008); cst(`RSC_ST_DST, 1);
    evt(11'h004); cst(`RSC_ST_DST, 0);
    evt(11'h008); dst_en = 0; tick(2); cst(`RSC_ST_DST, 0);
    $display("test status flags done");
    for (i = 0; i < 3; i++) begin
      code = 3'($urandom % 6);
      wr(`RSC_ADDR_SUPCTL, {5'h10, code}); seen = sclr; tick(1); seen |= sclr;
      chk({7'h0, seen}, 8'h01);
      chk({5'h0, trip}, {5'h0, code});
      rd(`RSC_ADDR_SUPCTL); chk(v, {5'h10, code});
    end
    wr(`RSC_ADDR_SUPCTL, 8'h06); rd(`RSC_ADDR_SUPCTL); chk(v, 8'h06);
    $display("test supply control done");
    wr(`RSC_ADDR_INTCTL, 8'h01); f0 = falls; tick(5000);
    chk({7'h0, (falls - f0) inside {[15:17]}}, 8'h01);
    wr(`RSC_ADDR_INTCTL, 8'h02); f0 = falls; tick(5000);
    chk({7'h0, (falls - f0) inside {[1:3]}}, 8'h01);
    wr(`RSC_ADDR_INTCTL, 8'h00); wr(`RSC_ADDR_STATUS, 8'h00); f0 = falls; tick(5000);
    chk(8'(falls - f0), 8'd0);
    $display("test frequency output done");
    complete_run();
  end
endmodule : test_rtc_status_interrupt_control
